//--- include/fcp_pkg.sv
// package: constants and carrier types for the flash command host
package fcp_pkg;
	localparam int FCP_CLK_NS = 10;
	localparam int FCP_ADDR_W = 16;
	localparam int FCP_DATA_W = 16;
	// strobe timings in ns
	localparam int FCP_WP_NS = 90;
	localparam int FCP_WPH_NS = 90;
	localparam int FCP_DS_NS = 50;
	localparam int FCP_AH_NS = 50;
	localparam int FCP_ACC_NS = 90;
	localparam int FCP_DF_NS = 25;
	localparam int FCP_POLL_HIGH_MIN_NS = 150;
	// cycle counts: least times rounded up
	localparam int FCP_WP_CYC = (FCP_WP_NS + FCP_CLK_NS - 1) / FCP_CLK_NS;
	localparam int FCP_WPH_CYC = (FCP_WPH_NS + FCP_CLK_NS - 1) / FCP_CLK_NS;
	localparam int FCP_ACC_CYC = (FCP_ACC_NS + FCP_CLK_NS - 1) / FCP_CLK_NS;
	localparam int FCP_DF_CYC = (FCP_DF_NS + FCP_CLK_NS - 1) / FCP_CLK_NS;
	localparam int FCP_POLL_HIGH_CYC = (FCP_POLL_HIGH_MIN_NS + FCP_CLK_NS - 1) / FCP_CLK_NS;
	localparam int FCP_CNT_W = 8;
	// command data and address values
	localparam logic [7:0] FCP_CHIP_ERASE_SEL = 8'h10;
	localparam logic [7:0] FCP_MAIN_ERASE_DATA = 8'h30;
	localparam logic [15:0] FCP_ID_MFR_ADDR = 16'h0000;
	localparam logic [15:0] FCP_ID_DEV_ADDR = 16'h0001;
	localparam logic [15:0] FCP_BOOT_LO = 16'h0000;
	localparam logic [15:0] FCP_BOOT_HI = 16'h1fff;
	localparam logic [14:0] FCP_CMD_ADDR_MASK = 15'h7fff;
	localparam logic [6:0] FCP_TOGGLE_BIT = 7'h06;
	localparam int FCP_SEQ_MAX = 6;

	typedef enum logic [2:0]
	{
		FCP_OP_READ,
		FCP_OP_WRITE,
		FCP_OP_POLL
	} fcp_op_e;

	typedef struct packed
	{
		fcp_op_e op;
		logic [15:0] addr;
		logic [15:0] data;
	} fcp_req_s;

	typedef struct packed
	{
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [15:0] addr;
		logic [15:0] dq_o;
		logic dq_oe;
	} fcp_pins_s;
endpackage

//--- logic/fcp_cnt.sv
// timer: loads a count and flags when it has run out
`timescale 1ns/1ps
module fcp_cnt
	import fcp_pkg::*;
#(
	parameter int W = FCP_CNT_W
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// status
	output logic done
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_r <= '0;
		else if (clk_en)
		begin
			if (load)
				cnt_r <= load_val;
			else if (cnt_r != '0)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	// no path from load to done, so a reload on done is no loop
	assign done = (cnt_r == '0);
endmodule

//--- logic/fcp_host.sv
// host sequencer that drives the flash strobes, address and data pins
`timescale 1ns/1ps
module fcp_host
	import fcp_pkg::*;
#(
	parameter int POLL_MAX = 65535
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// request side
	input wire logic req_valid,
	input wire fcp_req_s req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_timeout,
	// flash pins
	output fcp_pins_s pins,
	input wire logic [15:0] dq_i
);
	// ****************
	// state and timers
	// ****************
	typedef enum logic [3:0]
	{
		ST_IDLE,
		ST_WR_LOW,
		ST_WR_HIGH,
		ST_RD_LOW,
		ST_RD_FLOAT,
		ST_PL_LOW,
		ST_PL_HIGH,
		ST_DONE
	} fcp_state_e;

	fcp_state_e state_r;
	fcp_req_s req_r;
	logic t_load;
	logic [FCP_CNT_W-1:0] t_val;
	logic t_done;
	logic have_prev_r;
	logic prev_bit_r;
	logic [31:0] poll_cnt_r;
	logic cur_bit;
	logic settled_r;
	logic poll_stop;

	assign cur_bit = dq_i[FCP_TOGGLE_BIT[3:0]];
	assign poll_stop = settled_r || (poll_cnt_r >= 32'(POLL_MAX));

	fcp_cnt #(.W(FCP_CNT_W)) u_timer
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.load(t_load),
		.load_val(t_val),
		.done(t_done)
	);

	// ****************
	// sequencer
	// ****************
	always_comb
	begin
		t_load = 1'b0;
		t_val = '0;
		case (state_r)
			ST_IDLE:
			begin
				t_load = req_valid;
				t_val = (req.op == FCP_OP_WRITE) ? FCP_CNT_W'(FCP_WP_CYC - 1)
					: FCP_CNT_W'(FCP_ACC_CYC - 1);
			end
			ST_WR_LOW:
			begin
				t_load = t_done;
				t_val = FCP_CNT_W'(FCP_WPH_CYC - 1);
			end
			ST_RD_LOW:
			begin
				t_load = t_done;
				t_val = FCP_CNT_W'(FCP_DF_CYC - 1);
			end
			ST_PL_LOW:
			begin
				t_load = t_done;
				t_val = FCP_CNT_W'(FCP_POLL_HIGH_CYC - 1);
			end
			ST_PL_HIGH:
			begin
				t_load = t_done;
				t_val = FCP_CNT_W'(FCP_ACC_CYC - 1);
			end
			default:
				t_load = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			req_r <= '0;
		end
		else if (clk_en)
		begin
			case (state_r)
				ST_IDLE:
					if (req_valid)
					begin
						req_r <= req;
						case (req.op)
							FCP_OP_WRITE: state_r <= ST_WR_LOW;
							FCP_OP_POLL: state_r <= ST_PL_LOW;
							default: state_r <= ST_RD_LOW;
						endcase
					end
				ST_WR_LOW:
					if (t_done)
						state_r <= ST_WR_HIGH;
				ST_WR_HIGH:
					if (t_done)
						state_r <= ST_DONE;
				ST_RD_LOW:
					if (t_done)
						state_r <= ST_RD_FLOAT;
				ST_RD_FLOAT:
					if (t_done)
						state_r <= ST_DONE;
				ST_PL_LOW:
					if (t_done)
						state_r <= ST_PL_HIGH;
				ST_PL_HIGH:
					if (t_done)
					begin
						if (poll_stop)
							state_r <= ST_DONE;
						else
							state_r <= ST_PL_LOW;
					end
				ST_DONE:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************
	// toggle tracking
	// ****************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			have_prev_r <= 1'b0;
			prev_bit_r <= 1'b0;
			poll_cnt_r <= '0;
			settled_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (state_r == ST_IDLE)
			begin
				have_prev_r <= 1'b0;
				poll_cnt_r <= '0;
				settled_r <= 1'b0;
			end
			else if (state_r == ST_PL_LOW && t_done)
			begin
				have_prev_r <= 1'b1;
				settled_r <= have_prev_r && (prev_bit_r == cur_bit);
				prev_bit_r <= cur_bit;
				poll_cnt_r <= poll_cnt_r + 32'h1;
			end
		end
	end

	// ****************
	// pin drive
	// ****************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 16'h0000,
				dq_o: 16'h0000, dq_oe: 1'b0};
		end
		else if (clk_en)
		begin
			case (state_r)
				ST_IDLE:
					if (req_valid)
					begin
						pins.addr <= req.addr;
						pins.ce_n <= 1'b0;
						if (req.op == FCP_OP_WRITE)
						begin
							pins.dq_o <= req.data;
							pins.dq_oe <= 1'b1;
							pins.we_n <= 1'b0;
							// output enable held high on writes
							pins.oe_n <= 1'b1;
						end
						else
						begin
							pins.dq_oe <= 1'b0;
							pins.oe_n <= 1'b0;
						end
					end
				ST_WR_LOW:
					if (t_done)
					begin
						pins.we_n <= 1'b1;
						pins.ce_n <= 1'b1;
					end
				ST_WR_HIGH:
					if (t_done)
						pins.dq_oe <= 1'b0;
				ST_RD_LOW:
					if (t_done)
					begin
						pins.oe_n <= 1'b1;
						pins.ce_n <= 1'b1;
					end
				ST_PL_LOW:
					if (t_done)
					begin
						pins.oe_n <= 1'b1;
						pins.ce_n <= 1'b1;
					end
				ST_PL_HIGH:
					// low again only after high time
					if (t_done && !poll_stop)
					begin
						pins.oe_n <= 1'b0;
						pins.ce_n <= 1'b0;
					end
				default:
					pins.dq_oe <= 1'b0;
			endcase
		end
	end

	// ****************
	// answer
	// ****************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rsp_timeout <= 1'b0;
		end
		else if (clk_en)
		begin
			req_ready <= (state_r == ST_DONE) || (state_r == ST_IDLE && !req_valid);
			rsp_valid <= 1'b0;
			if (state_r == ST_RD_LOW && t_done)
				rsp_data <= dq_i;
			if (state_r == ST_PL_LOW && t_done)
				rsp_data <= dq_i;
			if (state_r == ST_PL_HIGH && t_done && poll_stop && !settled_r)
				rsp_timeout <= 1'b1;
			else if (state_r == ST_IDLE && req_valid)
				rsp_timeout <= 1'b0;
			if (state_r == ST_DONE)
				rsp_valid <= 1'b1;
		end
	end
endmodule

//--- testbench/fcp_flash_model.sv
// partner: behavioural flash with id mode, lockout and toggle status
`timescale 1ns/1ps
module fcp_flash_model
	import fcp_pkg::*;
#(
	parameter logic [15:0] MFR = 16'h00a5, // arbitrary value
	parameter logic [15:0] DEV = 16'h005a, // arbitrary value
	parameter logic [7:0] ID_IN = 8'h90,
	parameter logic [7:0] ID_OUT = 8'hf0,
	parameter logic [7:0] LOCK = 8'h40,
	parameter int BUSY_RD = 3
)
(
	// flash pins
	input wire fcp_pins_s pins,
	output logic [15:0] dq
);
	logic [15:0] mem [int];
	logic [15:0] q_r = 16'h0000;
	logic id_r = 1'b0;
	logic lock_r = 1'b0;
	logic tog_r = 1'b0;
	int busy = 0;
	always @(negedge pins.we_n)
	begin
		// let every pin of this edge settle first
		#1;
		if (!pins.ce_n)
		begin
			case (pins.dq_o[7:0])
				ID_IN: id_r = 1'b1;
				ID_OUT: id_r = 1'b0;
				LOCK: lock_r = 1'b1;
				default:
				begin
					if (!(lock_r && pins.addr <= FCP_BOOT_HI))
						mem[pins.addr] = pins.dq_o;
					busy = BUSY_RD;
				end
			endcase
		end
	end
	always @(negedge pins.oe_n)
	begin
		// let chip enable and address of this edge settle first
		#1;
		if (!pins.ce_n)
		begin
			if (id_r && pins.addr[15:1] == 15'h0000)
				q_r = pins.addr[0] ? DEV : MFR;
			else if (busy > 0)
			begin
				tog_r = !tog_r;
				q_r = {9'h000, tog_r, 6'h00};
				busy--;
			end
			else
				q_r = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
		end
	end
	// released bus shows the inverse
	assign dq = (!pins.ce_n && !pins.oe_n) ? q_r : ~q_r;
endmodule

//--- testbench/fcp_host_asserts.sv
// checker: pin protocol of the flash host
`timescale 1ns/1ps
module fcp_host_chk
	import fcp_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// request side
	input wire fcp_req_s req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	// flash pins
	input wire fcp_pins_s pins
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic seen_r;
	logic [7:0] hi_r;
	logic [15:0] la_r;
	// seen_r low between reads of one poll
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seen_r <= 1'b1;
			hi_r <= 8'h00;
			la_r <= 16'h0000;
		end
		else
		begin
			if (rsp_valid)
				seen_r <= 1'b1;
			else if (!pins.oe_n)
				seen_r <= 1'b0;
			hi_r <= pins.oe_n ? hi_r + 8'h01 : 8'h00;
			if ($fell(pins.ce_n))
				la_r <= pins.addr;
		end
	end
	oe_write_a: assert property (!pins.we_n && !pins.ce_n |-> pins.oe_n)
		else $error("oe low in write");
	drive_safe_a: assert property (pins.dq_oe |-> pins.oe_n)
		else $error("dq driven with oe low");
	both_strobes_a: assert property (pins.we_n |-> pins.ce_n == pins.oe_n)
		else $error("ce and oe split");
	poll_gap_a: assert property ($fell(pins.oe_n) && !seen_r |-> hi_r >= FCP_POLL_HIGH_CYC)
		else $error("poll gap short");
	poll_addr_a: assert property ($fell(pins.ce_n) && !seen_r |-> pins.addr == la_r)
		else $error("poll address moved");
	cmd_addr_a: assert property ($fell(pins.we_n) |-> pins.addr == $past(req.addr))
		else $error("write address wrong");
	cmd_data_a: assert property ($fell(pins.we_n) |-> pins.dq_o == $past(req.data))
		else $error("write data wrong");
	wp_len_a: assert property ($fell(pins.we_n) |-> !pins.we_n [*8] ##1 !pins.we_n ##1 pins.we_n)
		else $error("write pulse length");
	wr_done_a: assert property ($fell(pins.we_n) |-> ##19 rsp_valid)
		else $error("write answer late");
	ready_done_a: assert property (rsp_valid |-> req_ready)
		else $error("not ready at answer");
	cover property ($fell(pins.we_n));
	cover property ($fell(pins.oe_n) && !seen_r);
	cover property ($rose(rsp_valid));
endmodule
bind fcp_host fcp_host_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
	.req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins));

//--- testbench/test_flash_command_status_port.sv
// testbench: flash host sequencer against the flash model
`timescale 1ns/1ps
module test_flash_command_status_port;
	import fcp_pkg::*;
	localparam logic [15:0] MFR = 16'h00a5; // arbitrary value
	localparam logic [15:0] DEV = 16'h005a; // arbitrary value
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	fcp_req_s req = '0;
	logic req_ready, rsp_valid, rsp_timeout;
	logic [15:0] rsp_data, dq, a, d;
	fcp_pins_s pins;
	logic [16:0] exp_q [$];
	int mismatches = 0;
	int n_compared = 0;
	always #5 ref_clk = ~ref_clk;
	fcp_host #(.POLL_MAX(8)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .pins(pins), .dq_i(dq));
	fcp_flash_model #(.MFR(MFR), .DEV(DEV)) u_mem (.pins(pins), .dq(dq));
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		n_compared++;
		if (got !== want)
		begin
			mismatches++;
			$display("Error t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	task automatic check_flag(input logic got, input logic want);
		n_compared++;
		if (got !== want)
		begin
			mismatches++;
			$display("Error t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	task automatic op(input fcp_op_e o, input logic [15:0] ad, input logic [15:0] da,
		input logic chk, input logic [15:0] e);
		int n;
		exp_q.push_back({chk, e});
		@(negedge ref_clk);
		req = '{o, ad, da};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1)
		begin
			@(negedge ref_clk);
			n++;
			if (n > 500)
			begin
				mismatches++;
				give_verdict();
			end
		end
	endtask
	always @(posedge ref_clk)
	begin
		logic [16:0] e;
		if (rsp_valid === 1'b1)
		begin
			e = exp_q.pop_front();
			if (e[16])
				check(rsp_data, e[15:0]);
			check_flag(rsp_timeout, 1'b0);
		end
	end
	initial
	begin
		void'($urandom(38));
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		op(FCP_OP_WRITE, {8'h00, FCP_CHIP_ERASE_SEL}, {8'h00, FCP_MAIN_ERASE_DATA}, 0, 0);
		op(FCP_OP_POLL, 16'h0010, 16'h0000, 1'b1, 16'h0030);
		for (int i = 0; i < 4; i++)
		begin
			a = 16'h2000 + 16'($urandom % 32'he000);
			d = 16'($urandom) | 16'h0001;
			op(FCP_OP_WRITE, a, d, 1'b0, 16'h0000);
			op(FCP_OP_POLL, a, 16'h0000, 1'b1, d);
			op(FCP_OP_READ, a, 16'h0000, 1'b1, d);
		end
		op(FCP_OP_WRITE, 16'h5555, 16'hab90, 1'b0, 16'h0000);
		op(FCP_OP_READ, 16'h0000, 16'h0000, 1'b1, MFR);
		op(FCP_OP_READ, 16'h0001, 16'h0000, 1'b1, DEV);
		op(FCP_OP_WRITE, 16'hd555, 16'h12f0, 1'b0, 16'h0000);
		op(FCP_OP_READ, a, 16'h0000, 1'b1, d);
		op(FCP_OP_WRITE, 16'h5555, 16'h0040, 1'b0, 16'h0000);
		op(FCP_OP_WRITE, FCP_BOOT_HI, 16'h1235, 1'b0, 16'h0000);
		op(FCP_OP_POLL, FCP_BOOT_HI, 16'h0000, 1'b1, 16'hffff);
		op(FCP_OP_WRITE, 16'h2000, 16'h1235, 1'b0, 16'h0000);
		op(FCP_OP_POLL, 16'h2000, 16'h0000, 1'b1, 16'h1235);
		give_verdict();
	end
endmodule
